/* design/tpgc_frame_divider.sv */
// frame rate enable divider for the tone pattern block
`timescale 1ns/10ps
module tpgc_frame_divider
    import tpgc_pkg::*;
#(
    parameter int unsigned PERIOD = FRAME_PERIOD_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    localparam logic [FRAME_CNT_W-1:0] LAST = FRAME_CNT_W'(PERIOD - 1);

    typedef struct packed {
        logic [FRAME_CNT_W-1:0] count;
        logic tick;
    } tpgc_div_type;

    tpgc_div_type q;
    tpgc_div_type n;

    // ==========================================================
    // counter
    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (q.count == LAST) begin
            n.count = '0;
            n.tick = 1'b1;
        end else begin
            n.count = q.count + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick = q.tick;
endmodule

/* design/tpgc_top.sv */
// tone pattern and gain control with an AXI4-Lite register slave
`timescale 1ns/10ps
module tpgc_top
    import tpgc_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_PERIOD_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tone1_on,
    output logic tone2_on,
    output logic [4:0] tone_freq_sel,
    output logic [1:0] triple_step,
    output logic [6:0] tone_atten_half_db
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [4:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] freq_reg;
        logic [4:0] ctrl_reg;
        logic [4:0] level_reg;
        tpgc_phase_type phase;
        logic [INT_W-1:0] interval;
        logic [1:0] step;
        logic app_mode;
        logic [2:0] app_pattern;
        logic [4:0] app_freq;
        logic [4:0] app_level;
        logic tone1;
        logic tone2;
        logic [1:0] triple_out;
        logic [6:0] atten;
    } tpgc_state_type;

    localparam tpgc_state_type STATE_RESET = '{
        awready: 1'b0,
        wready: 1'b0,
        aw_have: 1'b0,
        awaddr: 8'h00,
        w_have: 1'b0,
        wdata: 5'h00,
        wstrb0: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: RESP_OKAY,
        freq_reg: FREQ_RESET,
        ctrl_reg: CTRL_RESET,
        level_reg: LEVEL_RESET,
        phase: ST_IDLE,
        interval: 14'h0000,
        step: 2'h0,
        app_mode: 1'b0,
        app_pattern: PAT_CONT,
        app_freq: FREQ_RESET,
        app_level: LEVEL_RESET,
        tone1: 1'b0,
        tone2: 1'b0,
        triple_out: 2'h0,
        atten: ATTEN_RESET
    };

    tpgc_state_type q;
    tpgc_state_type n;
    logic frame_tick;
    logic [31:0] status_word;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic wr_go;
    logic ctrl_wr;
    logic run_req;
    logic mode_req;
    logic [2:0] pat_req;

    // ==========================================================
    // frame rate enable
    tpgc_frame_divider #(
        .PERIOD(FRAME_CYCLES)
    ) u_frame_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(frame_tick)
    );

    // ==========================================================
    // interval lengths, loaded as count minus one
    function automatic logic [INT_W-1:0] tone_len(input logic [2:0] pat);
        case (pat)
            PAT_31MS: tone_len = CNT_31MS - 14'h0001;
            PAT_200MS: tone_len = CNT_200MS - 14'h0001;
            PAT_250MS: tone_len = CNT_250MS - 14'h0001;
            PAT_500MS: tone_len = CNT_500MS - 14'h0001;
            PAT_1S: tone_len = CNT_1S - 14'h0001;
            PAT_TRIPLE: tone_len = CNT_TRIPLE - 14'h0001;
            PAT_ONESHOT: tone_len = CNT_200MS - 14'h0001;
            default: tone_len = 14'h0000;
        endcase
    endfunction

    function automatic logic [INT_W-1:0] gap_len(input logic [2:0] pat);
        if (pat == PAT_TRIPLE) begin
            gap_len = CNT_1S - 14'h0001;
        end else begin
            gap_len = tone_len(pat);
        end
    endfunction

    // gain code to attenuation in half dB
    function automatic logic [6:0] level_atten(input logic [4:0] code);
        if (code == LEVEL_DEEP_CODE) begin
            level_atten = ATTEN_DEEP_HALF_DB;
        end else begin
            level_atten = {1'b0, code, 1'b0};
        end
    endfunction

    // ==========================================================
    // status word
    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_RUNNING_BIT] = (q.phase != ST_IDLE);
        status_word[STAT_TONE1_BIT] = q.tone1;
        status_word[STAT_TONE2_BIT] = q.tone2;
        status_word[STAT_STEP_LSB +: 2] = q.triple_out;
        status_word[STAT_FREQ_LSB +: 5] = q.app_freq;
        status_word[STAT_LEVEL_LSB +: 5] = q.app_level;
        status_word[STAT_MODE_BIT] = q.app_mode;
        status_word[STAT_PAT_LSB +: 3] = q.app_pattern;
    end

    // ==========================================================
    // fields of the held control write
    always_comb begin
        run_req = q.wdata[CTRL_RUN_BIT];
        mode_req = q.wdata[CTRL_MODE_BIT];
        pat_req = q.wdata[CTRL_PAT_LSB +: 3];
    end

    // ==========================================================
    // next state
    always_comb begin
        n = q;
        wr_go = 1'b0;
        ctrl_wr = 1'b0;
        wr_addr = q.awaddr & ADDR_WORD_MASK;
        rd_addr = s_axi_araddr & ADDR_WORD_MASK;

        // write channel capture, in either order
        if (s_axi_awvalid && q.awready) begin
            n.aw_have = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.w_have = 1'b1;
            n.wdata = s_axi_wdata[4:0];
            n.wstrb0 = s_axi_wstrb[0];
        end

        // write execution once both halves are held; a second write
        // waits until the previous response has been taken
        if (q.aw_have && q.w_have && !q.bvalid) begin
            wr_go = 1'b1;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (wr_addr)
                ADDR_FREQ: begin
                    if (q.wstrb0) begin
                        n.freq_reg = q.wdata;
                    end
                end
                ADDR_TONE_CTRL: begin
                    if (q.wstrb0) begin
                        n.ctrl_reg = q.wdata;
                    end
                end
                ADDR_TONE_LEVEL: begin
                    if (q.wstrb0) begin
                        n.level_reg = q.wdata;
                    end
                end
                ADDR_STATUS: begin
                    n.bresp = RESP_OKAY;
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end
        // only a stored control byte may start or stop the tone
        ctrl_wr = wr_go && q.wstrb0 && (wr_addr == ADDR_TONE_CTRL);
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
        end

        // read channel
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h00000000;
            case (rd_addr)
                ADDR_STATUS: begin
                    n.rdata = status_word;
                end
                ADDR_FREQ, ADDR_TONE_CTRL, ADDR_TONE_LEVEL: begin
                    n.rdata = 32'h00000000;
                end
                default: begin
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end

        // pattern sequencing on frame ticks
        // a continuous tone never counts down
        if (frame_tick && q.phase != ST_IDLE
                && q.app_pattern != PAT_CONT) begin
            if (q.interval != 14'h0000) begin
                n.interval = q.interval - 14'h0001;
            end else begin
                case (q.phase)
                    ST_TONE: begin
                        if (q.app_pattern == PAT_ONESHOT) begin
                            n.phase = ST_IDLE;
                        end else if (q.app_pattern == PAT_TRIPLE
                                && q.step != TRIPLE_LAST) begin
                            n.step = q.step + 2'h1;
                            n.interval = tone_len(q.app_pattern);
                        end else begin
                            n.phase = ST_GAP;
                            n.interval = gap_len(q.app_pattern);
                        end
                    end
                    ST_GAP: begin
                        n.phase = ST_TONE;
                        n.step = 2'h0;
                        n.interval = tone_len(q.app_pattern);
                    end
                    default: begin
                        n.phase = ST_IDLE;
                    end
                endcase
            end
        end

        // start or stop; only a control write alters the tone
        if (ctrl_wr) begin
            if (run_req) begin
                // frequency choice taken here; later writes wait
                n.app_freq = q.freq_reg;
                n.app_mode = mode_req;
                n.app_pattern = pat_req;
                n.phase = ST_TONE;
                n.step = 2'h0;
                n.interval = tone_len(pat_req);
            end else begin
                n.phase = ST_IDLE;
            end
        end

        // gain follows the level register each frame
        // so a new code needs no start command
        if (frame_tick) begin
            n.app_level = q.level_reg;
        end

        // registered outputs
        n.awready = !n.aw_have;
        n.wready = !n.w_have;
        n.arready = !n.rvalid;
        n.tone1 = (n.phase == ST_TONE);
        n.tone2 = (n.phase == ST_TONE) && n.app_mode
            && (n.app_pattern != PAT_TRIPLE);
        if (n.phase == ST_TONE && n.app_pattern == PAT_TRIPLE) begin
            n.triple_out = n.step + 2'h1;
        end else begin
            n.triple_out = 2'h0;
        end
        n.atten = level_atten(n.app_level);
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= STATE_RESET;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign tone1_on = q.tone1;
    assign tone2_on = q.tone2;
    assign tone_freq_sel = q.app_freq;
    assign triple_step = q.triple_out;
    assign tone_atten_half_db = q.atten;
endmodule

/* shared/tpgc_pkg.sv */
// constants shared by the tone pattern and gain control block
// ==========================================================
// Summary of operation
// - bit4 single/dual, bits3..1 pattern, bit0 run; all clear at reset
// - writing run=1, from 0 or 1, applies frequency choice and restarts
// - output other than gain only begins or changes on a control write
// - control write with run clear stops the tone, other bits ignored
// - pattern 000 sounds continuously until a stop command
// - pattern 001 alternates 31.25 ms tone and 31.25 ms silence
// - patterns 010, 011, 100 alternate 200, 250, 500 ms tone and silence
// - pattern 101 alternates one second tone with one second silence
// - pattern 111 gives one 200 ms burst then stays silent
// - pattern 110 plays 950, 1400, 1800 Hz for 333 ms each, 1 s silence
// - pattern 110 always runs in single tone mode
// - mode bit 1 sounds tone 1 and tone 2 together with the pattern
// - five-bit gain field sets attenuation of the generated tone
// - gain codes 0..30 give 0..-30 dB in 1 dB steps; 31 gives -38.5 dB
// - frequency choice is latched at once but used only at next start
// - dual pair in single mode sounds only tone 1
package tpgc_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_FREQ = 4'h4;
    localparam logic [3:0] IDX_TONE_CTRL = 4'h5;
    localparam logic [3:0] IDX_TONE_LEVEL = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [7:0] ADDR_FREQ = {2'h0, IDX_FREQ, 2'h0};
    localparam logic [7:0] ADDR_TONE_CTRL = {2'h0, IDX_TONE_CTRL, 2'h0};
    localparam logic [7:0] ADDR_TONE_LEVEL = {2'h0, IDX_TONE_LEVEL, 2'h0};
    localparam logic [7:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control field layout
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PAT_LSB = 1;
    localparam int CTRL_MODE_BIT = 4;
    // status word layout
    localparam int STAT_RUNNING_BIT = 0;
    localparam int STAT_TONE1_BIT = 1;
    localparam int STAT_TONE2_BIT = 2;
    localparam int STAT_STEP_LSB = 3;
    localparam int STAT_FREQ_LSB = 5;
    localparam int STAT_LEVEL_LSB = 10;
    localparam int STAT_MODE_BIT = 15;
    localparam int STAT_PAT_LSB = 16;
    // reset values
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [4:0] LEVEL_RESET = 5'h14;
    localparam logic [4:0] FREQ_RESET = 5'h13;
    // pattern codes
    localparam logic [2:0] PAT_CONT = 3'h0;
    localparam logic [2:0] PAT_31MS = 3'h1;
    localparam logic [2:0] PAT_200MS = 3'h2;
    localparam logic [2:0] PAT_250MS = 3'h3;
    localparam logic [2:0] PAT_500MS = 3'h4;
    localparam logic [2:0] PAT_1S = 3'h5;
    localparam logic [2:0] PAT_TRIPLE = 3'h6;
    localparam logic [2:0] PAT_ONESHOT = 3'h7;
    // gain code with the extra-deep step, attenuation in half dB
    localparam logic [4:0] LEVEL_DEEP_CODE = 5'h1F;
    localparam logic [6:0] ATTEN_DEEP_HALF_DB = 7'h4D;
    localparam logic [6:0] ATTEN_RESET = {1'b0, LEVEL_RESET, 1'b0};
    // timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned FRAME_HZ = 8000;
    localparam int unsigned FRAME_PERIOD_CYCLES = CLK_HZ / FRAME_HZ;
    localparam int FRAME_CNT_W = 12;
    localparam real FRAME_US = 125.0;
    localparam real T_31MS_MS = 31.25;
    localparam real T_200MS_MS = 200.0;
    localparam real T_250MS_MS = 250.0;
    localparam real T_500MS_MS = 500.0;
    localparam real T_1S_MS = 1000.0;
    localparam real T_TRIPLE_MS = 333.0;
    localparam int INT_W = 14;
    localparam logic [13:0] CNT_31MS =
        14'(int'(T_31MS_MS * 1000.0 / FRAME_US));
    localparam logic [13:0] CNT_200MS =
        14'(int'(T_200MS_MS * 1000.0 / FRAME_US));
    localparam logic [13:0] CNT_250MS =
        14'(int'(T_250MS_MS * 1000.0 / FRAME_US));
    localparam logic [13:0] CNT_500MS =
        14'(int'(T_500MS_MS * 1000.0 / FRAME_US));
    localparam logic [13:0] CNT_1S =
        14'(int'(T_1S_MS * 1000.0 / FRAME_US));
    localparam logic [13:0] CNT_TRIPLE =
        14'(int'(T_TRIPLE_MS * 1000.0 / FRAME_US));
    localparam logic [1:0] TRIPLE_LAST = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TONE,
        ST_GAP
    } tpgc_phase_type;
endpackage

/* tb/tpgc_axi_master.sv */
// controller model issuing register cycles over AXI4-Lite
`timescale 1ns/10ps
module tpgc_axi_master
    import tpgc_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic run_q = 1'b0;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw_p;
        logic w_p;
        // no frequency choice while a tone runs
        if (a == ADDR_FREQ && run_q) begin
            r = 2'h3;
            return;
        end
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        do begin
            @(posedge aclk);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (a == ADDR_TONE_CTRL) run_q = d[0];
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

/* tb/tpgc_props.sv */
// assertion checker for the tone pattern and gain control block
`timescale 1ns/10ps
module tpgc_props
    import tpgc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tone1_on,
    input wire logic tone2_on,
    input wire logic [4:0] tone_freq_sel,
    input wire logic [1:0] triple_step,
    input wire logic [6:0] tone_atten_half_db
);
    // ==========================================================
    // helper terms
    wire aw_t = s_axi_awvalid && s_axi_awready;
    wire w_t = s_axi_wvalid && s_axi_wready;
    wire ctl_wr = aw_t && w_t && s_axi_wstrb[0]
        && ((s_axi_awaddr & ADDR_WORD_MASK) == ADDR_TONE_CTRL);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        aw_t && w_t;
    endsequence
    sequence s_start;
        ctl_wr && s_axi_wdata[CTRL_RUN_BIT];
    endsequence
    sequence s_stop;
        ctl_wr && !s_axi_wdata[CTRL_RUN_BIT];
    endsequence
    // ==========================================================
    // properties
    a_b_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("no write response after take");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer after take");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_start_tone: assert property (
        s_start |-> ##2 tone1_on) else $error("start gave no tone");
    a_stop_tone: assert property (
        s_stop |-> ##2 (!tone1_on && !tone2_on && triple_step == 2'h0))
        else $error("stop left tone running");
    a_tone2_mode: assert property (
        tone2_on |-> tone1_on && triple_step == 2'h0)
        else $error("tone 2 outside dual mode");
    a_atten_code: assert property (
        tone_atten_half_db == ATTEN_DEEP_HALF_DB
        || (!tone_atten_half_db[0] && tone_atten_half_db <= 7'h3C))
        else $error("attenuation off the code table");
    a_freq_start: assert property (
        $changed(tone_freq_sel) |-> $past(ctl_wr && s_axi_wdata[0], 2))
        else $error("frequency applied without start");
endmodule
bind tpgc_top tpgc_props u_tpgc_props (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .tone1_on, .tone2_on, .tone_freq_sel,
    .triple_step, .tone_atten_half_db);

/* tb/tpgc_top_tb.sv */
// self-checking bench for the tone pattern and gain control block
`timescale 1ns/10ps
module tpgc_top_tb
    import tpgc_pkg::*;
();
    localparam int F = 4;
    localparam int LIM = 95000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, triple_step;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, tone1_on, tone2_on;
    logic [4:0] tone_freq_sel;
    logic [6:0] tone_atten_half_db;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    tpgc_top #(.FRAME_CYCLES(F)) u_tpgc_top (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tone1_on, .tone2_on, .tone_freq_sel, .triple_step,
        .tone_atten_half_db);
    tpgc_axi_master u_tpgc_axi_master (.aclk, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ==========================================================
    // checking and bus helpers
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic [1:0] r;
        u_tpgc_axi_master.wr(a, d, r);
        chk(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_tpgc_axi_master.rd(a, d, r);
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask
    // cycles spent with tone 1 at one level
    task automatic hold_len(input logic lvl, output int k);
        k = 0;
        while (tone1_on === lvl && k < 40000) begin
            @(posedge aclk);
            k++;
        end
    endtask
    // start a pattern and time its first tone interval of k frames
    task automatic run_pat(input logic [4:0] c, input int k);
        int len;
        wr(ADDR_TONE_CTRL, 32'(c), RESP_OKAY);
        chk(32'(tone1_on), 32'h1);
        chk(32'(tone2_on), 32'(c[4]));
        hold_len(1'b1, len);
        chk_in(len, (k - 1) * F - 4, k * F);
    endtask
    task automatic lvl(input logic [4:0] c, input logic [6:0] e);
        wr(ADDR_TONE_LEVEL, 32'(c), RESP_OKAY);
        repeat (F + 2) @(posedge aclk);
        chk(32'(tone_atten_half_db), 32'(e));
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk(32'(tone_atten_half_db), 32'(ATTEN_RESET));
        chk(32'(tone1_on), 32'h0);
        rd(ADDR_STATUS, (32'(LEVEL_RESET) << STAT_LEVEL_LSB)
            | (32'(FREQ_RESET) << STAT_FREQ_LSB), RESP_OKAY);
        rd(ADDR_TONE_CTRL, 32'h0, RESP_OKAY);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_latch();
        wr(ADDR_FREQ, 32'h08, RESP_OKAY);
        wr(ADDR_TONE_CTRL, 32'h10, RESP_OKAY);
        chk(32'(tone1_on), 32'h0);
        chk(32'(tone_freq_sel), 32'(FREQ_RESET));
        wr(ADDR_TONE_CTRL, 32'h11, RESP_OKAY);
        chk(32'(tone_freq_sel), 32'h08);
        repeat (300) @(posedge aclk);
        chk(32'(tone1_on), 32'h1);
        chk(32'(tone2_on), 32'h1);
        lvl(5'h1F, ATTEN_DEEP_HALF_DB);
        lvl(5'h1E, 7'h3C);
        lvl(5'h00, 7'h00);
        wr(ADDR_TONE_CTRL, 32'h1E, RESP_OKAY);
        chk(32'(tone1_on | tone2_on), 32'h0);
        wr(ADDR_TONE_CTRL, 32'h01, RESP_OKAY);
        chk(32'(tone1_on), 32'h1);
        chk(32'(tone2_on), 32'h0);
    endtask
    task automatic t_patterns();
        wr(ADDR_TONE_CTRL, 32'h03, RESP_OKAY);
        repeat (500) @(posedge aclk);
        run_pat(5'h03, 250);
        hold_len(1'b0, n);
        chk_in(n, 250 * F - 1, 250 * F + 1);
        run_pat(5'h15, 1600);
        run_pat(5'h07, 2000);
        run_pat(5'h19, 4000);
        run_pat(5'h0B, 8000);
        run_pat(5'h1F, 1600);
        repeat (1000) @(posedge aclk);
        chk(32'(tone1_on), 32'h0);
        rd(ADDR_STATUS, (32'h08 << STAT_FREQ_LSB) | (32'h1 << STAT_MODE_BIT)
            | (32'(PAT_ONESHOT) << STAT_PAT_LSB), RESP_OKAY);
    endtask
    task automatic t_triple();
        wr(ADDR_TONE_CTRL, 32'h1D, RESP_OKAY);
        chk(32'(tone2_on), 32'h0);
        chk(32'(triple_step), 32'h1);
        n = 0;
        while (triple_step === 2'h1 && n < 12000) begin
            @(posedge aclk);
            n++;
        end
        chk_in(n, 2663 * F - 4, 2664 * F);
        chk(32'({tone1_on, triple_step}), 32'h6);
        wr(ADDR_TONE_CTRL, 32'h00, RESP_OKAY);
        chk(32'({tone1_on, triple_step}), 32'h0);
    endtask
    // ==========================================================
    // clock, timeout and main sequence
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIM) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_latch();
        t_patterns();
        t_triple();
        finish_test();
    end
endmodule
